// [include/itc_pkg.sv]
// Shared constants and types of the two-wire bus control block.
// Assumes an 8-bit host port with three address lines and a 25 MHz clock.
package itc_pkg;
   // Host port selects; the control register sits at select 2
   localparam logic [2:0] ITC_A_CTRL = 3'h2;
   localparam logic [2:0] ITC_A_STAT = 3'h3;
   localparam logic [2:0] ITC_A_SRST = 3'h7;
   // Control register field positions
   localparam int ITC_B_IRQ = 7;
   localparam int ITC_B_ON = 6;
   localparam int ITC_B_BEGIN = 5;
   localparam int ITC_B_STOP = 4;
   localparam int ITC_B_FLAG = 3;
   localparam int ITC_B_ACK = 2;
   // Values after reset
   localparam logic [7:0] ITC_CTRL_RST = 8'h00;
   localparam logic [7:0] ITC_STAT_RST = 8'hF8;
   // Status codes
   localparam logic [7:0] ITC_S_START = 8'h08;
   localparam logic [7:0] ITC_S_RSTART = 8'h10;
   localparam logic [7:0] ITC_S_AW_ACK = 8'h18;
   localparam logic [7:0] ITC_S_AW_NAK = 8'h20;
   localparam logic [7:0] ITC_S_TX_ACK = 8'h28;
   localparam logic [7:0] ITC_S_TX_NAK = 8'h30;
   localparam logic [7:0] ITC_S_ARB = 8'h38;
   localparam logic [7:0] ITC_S_AR_ACK = 8'h40;
   localparam logic [7:0] ITC_S_AR_NAK = 8'h48;
   localparam logic [7:0] ITC_S_RX_ACK = 8'h50;
   localparam logic [7:0] ITC_S_RX_NAK = 8'h58;
   localparam logic [7:0] ITC_S_SW_ACK = 8'h60;
   localparam logic [7:0] ITC_S_GC_ACK = 8'h70;
   localparam logic [7:0] ITC_S_SRX_ACK = 8'h80;
   localparam logic [7:0] ITC_S_SRX_NAK = 8'h88;
   localparam logic [7:0] ITC_S_GRX_ACK = 8'h90;
   localparam logic [7:0] ITC_S_GRX_NAK = 8'h98;
   localparam logic [7:0] ITC_S_SSTOP = 8'hA0;
   localparam logic [7:0] ITC_S_SR_ACK = 8'hA8;
   localparam logic [7:0] ITC_S_STX_ACK = 8'hB8;
   localparam logic [7:0] ITC_S_STX_NAK = 8'hC0;
   localparam logic [7:0] ITC_S_SLAST = 8'hC8;
   localparam logic [7:0] ITC_S_NONE = 8'hF8;
   // First byte of a 10-bit address starts with this pattern
   localparam logic [4:0] ITC_TENB_PFX = 5'h1E;
   // Master clock half period, 100 kHz bus
   localparam int ITC_CLK_NS = 40;
   localparam int ITC_HALF_NS = 5000;
   localparam int ITC_HALF_CYC = (ITC_HALF_NS + ITC_CLK_NS - 1) / ITC_CLK_NS;
   // Controller states, Gray in the order listed
   typedef enum logic [2:0] {
      ITC_IDLE = 3'b000,
      ITC_START = 3'b001,
      ITC_BYTE = 3'b011,
      ITC_ACK = 3'b010,
      ITC_HOLD = 3'b110,
      ITC_STOP = 3'b111
   } itc_state_t;
   // One host port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } itc_cpu_req_t;
endpackage : itc_pkg

// [logic/itc_ctrl.sv]
// Two-wire bus controller: control/status registers,
// start/stop, byte engine, ack and stretch.
// Assumes open-drain pads; addresses and transmit byte
// come from neighbouring registers.
// Functional notes
// - Interrupt line high while flag set and interrupt allow bit is one.
// - Controller on: answer own slave address, general call if accepted.
// - Controller off: bus inputs ignored, no address answered.
// - Begin request starts master mode with START once bus free; writing 0 ignored.
// - Begin request while master after bytes sends a repeated START.
// - Begin request during slave access waits until the bus is released.
// - Begin request clears itself once START has been sent.
// - Stop request in master mode sends STOP on the bus.
// - Stop request in slave mode acts like a received STOP, nothing driven.
// - Begin and stop together: STOP first if master, then START.
// - Stop request clears itself after the stop action.
// - Flag set on entering every defined state except no-information F8h.
// - While flag set, clock line held low to suspend transfer, except after 38h and A0h.
// - Flag cleared: interrupt line low, clock line released.
// - Ack on 7-bit address or either 10-bit address byte when ack bit set.
// - Ack general call only when general call is accepted.
// - Ack each received data byte in master or slave mode while ack bit set.
// - Ack bit clear gives not-ack; slave transmitter ends via C8h then idle.
// - No slave response while ack bit is zero.
// - Clearing the flag returns status to F8h.
// - Software reset write returns idle, clears begin, stop and flag.
`timescale 1ns/10ps
`default_nettype none
module itc_ctrl #(
   parameter int FIFO_DEPTH = 32
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Host register port
   input wire itc_pkg::itc_cpu_req_t cpu_req,
   output logic [7:0] cpu_rdata,
   output logic interrupt_line,
   // Address settings
   input wire logic [6:0] slave_addr,
   input wire logic general_call_accept,
   input wire logic ext_addr_on,
   input wire logic [9:0] ext_addr,
   // Byte streams
   input wire logic [7:0] tx_byte,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready,
   // Two-wire bus pins
   input wire logic data_line_input,
   output logic data_line_out,
   output logic data_line_oe,
   input wire logic clock_line_input,
   output logic clock_line_out,
   output logic clock_line_oe
);
   import itc_pkg::*;

   typedef struct packed {
      itc_state_t st;
      logic irq_on, ctl_on, begin_req, stop_req, flag, ack_on;
      logic [7:0] status;
      logic [2:0] sda_sy, scl_sy;
      logic sda_f, scl_f, sda_p, scl_p;
      logic busy, master, slave, gcall, tenb, done;
      logic tx, rw, first, last, ack_in;
      logic [7:0] pend;
      logic [7:0] shreg;
      logic [3:0] cnt;
      logic [1:0] ph;
      logic [7:0] div;
      logic scl_oe, sda_oe, irq;
      logic [7:0] rdata;
   } itc_regs_t;

   itc_regs_t q;
   itc_regs_t n;
   logic rx_push;
   logic fifo_in_ready;

   // Pins are open drain: only the enables move
   assign data_line_out = 1'b0;
   assign clock_line_out = 1'b0;
   assign data_line_oe = q.sda_oe;
   assign clock_line_oe = q.scl_oe;
   assign interrupt_line = q.irq;
   assign cpu_rdata = q.rdata;

   // Received bytes wait here; a full FIFO stretches the clock
   itc_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .clock(clock),
      .sys_rst(sys_rst),
      .in_valid(rx_push),
      .in_data(q.shreg),
      .in_ready(fifo_in_ready),
      .out_valid(rx_valid),
      .out_data(rx_data),
      .out_ready(rx_ready)
   );

   // Next-state logic of the whole controller
   always_comb begin
      logic sda_v, scl_v, rise, fall, s_start, s_stop, m_tick;
      logic hw_set, ackd;
      logic [7:0] hw_code, ctrl;
      sda_v = 1'b1;
      scl_v = 1'b1;
      hw_set = 1'b0;
      hw_code = ITC_S_NONE;
      ctrl = ITC_CTRL_RST;
      n = q;
      rx_push = 1'b0;
      // Three stages; a change counts once stages two and three agree
      n.sda_sy = {q.sda_sy[1:0], data_line_input};
      n.scl_sy = {q.scl_sy[1:0], clock_line_input};
      if (q.sda_sy[1] == q.sda_sy[2]) begin
         n.sda_f = q.sda_sy[2];
      end
      if (q.scl_sy[1] == q.scl_sy[2]) begin
         n.scl_f = q.scl_sy[2];
      end
      // A disabled controller sees an idle bus
      sda_v = q.sda_f | ~q.ctl_on;
      scl_v = q.scl_f | ~q.ctl_on;
      n.sda_p = sda_v;
      n.scl_p = scl_v;
      rise = scl_v & ~q.scl_p;
      fall = ~scl_v & q.scl_p;
      s_start = scl_v & q.scl_p & q.sda_p & ~sda_v;
      s_stop = scl_v & q.scl_p & ~q.sda_p & sda_v;
      ackd = q.ack_on;
      // Half-period enable for the master clock
      m_tick = (q.div == 8'h00);
      n.div = m_tick ? 8'(ITC_HALF_CYC - 1) : q.div - 8'h01;
      if (s_start) begin
         n.busy = 1'b1;
      end
      if (s_stop) begin
         n.busy = 1'b0;
      end

      // Master clock toggling; a slave stretching low holds the high phase
      if (q.master && (q.st == ITC_BYTE || q.st == ITC_ACK) && m_tick) begin
         if (q.scl_oe) begin
            n.scl_oe = 1'b0;
         end else if (scl_v) begin
            n.scl_oe = 1'b1;
         end
      end

      unique case (q.st)
         ITC_IDLE: begin
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
            n.stop_req = 1'b0;
            if (q.begin_req && !q.busy && q.ctl_on) begin
               n.st = ITC_START;
               n.ph = 2'd0;
            end else if (s_start) begin
               n.st = ITC_BYTE;
               n.first = 1'b1;
               n.tenb = 1'b0;
               n.tx = 1'b0;
               n.cnt = 4'd0;
            end
         end
         ITC_START: begin
            // Release data, release clock, pull data under high clock, then clock
            if (m_tick) begin
               unique case (q.ph)
                  2'd0: begin
                     n.sda_oe = 1'b0;
                     n.ph = 2'd1;
                  end
                  2'd1: begin
                     n.scl_oe = 1'b0;
                     n.ph = 2'd2;
                  end
                  2'd2: begin
                     if (scl_v) begin
                        n.sda_oe = 1'b1;
                        n.ph = 2'd3;
                     end
                  end
                  2'd3: begin
                     n.scl_oe = 1'b1;
                     n.begin_req = 1'b0;
                     hw_set = 1'b1;
                     hw_code = q.master ? ITC_S_RSTART : ITC_S_START;
                     n.master = 1'b1;
                     n.slave = 1'b0;
                     n.first = 1'b1;
                     n.tx = 1'b1;
                     n.st = ITC_HOLD;
                  end
               endcase
            end
         end
         ITC_BYTE: begin
            if (rise && q.cnt != 4'd8) begin
               n.shreg = {q.shreg[6:0], sda_v};
               n.cnt = q.cnt + 4'd1;
               // Sent a one but the bus shows zero: another master won
               if (q.master && q.tx && !q.sda_oe && !sda_v) begin
                  n.master = 1'b0;
                  n.scl_oe = 1'b0;
                  n.st = ITC_IDLE;
                  hw_set = 1'b1;
                  hw_code = ITC_S_ARB;
               end
            end else if (q.cnt == 4'd8 && !scl_v) begin
               if (!q.tx && !q.first && !fifo_in_ready) begin
                  n.scl_oe = 1'b1;
               end else begin
                  n.st = ITC_ACK;
                  if (!q.master) begin
                     n.scl_oe = 1'b0;
                  end
                  if (q.tx) begin
                     n.sda_oe = 1'b0;
                  end else if (!q.first) begin
                     rx_push = 1'b1;
                     n.sda_oe = ackd;
                     if (q.master) begin
                        n.pend = ackd ? ITC_S_RX_ACK : ITC_S_RX_NAK;
                     end else if (q.gcall) begin
                        n.pend = ackd ? ITC_S_GRX_ACK : ITC_S_GRX_NAK;
                     end else begin
                        n.pend = ackd ? ITC_S_SRX_ACK : ITC_S_SRX_NAK;
                     end
                  end else if (ackd && !q.tenb && q.shreg[7:1] == slave_addr) begin
                     n.sda_oe = 1'b1;
                     n.slave = 1'b1;
                     n.gcall = 1'b0;
                     n.rw = q.shreg[0];
                     n.pend = q.shreg[0] ? ITC_S_SR_ACK : ITC_S_SW_ACK;
                  end else if (ackd && q.shreg == 8'h00 && general_call_accept) begin
                     n.sda_oe = 1'b1;
                     n.slave = 1'b1;
                     n.gcall = 1'b1;
                     n.rw = 1'b0;
                     n.pend = ITC_S_GC_ACK;
                  end else if (ackd && ext_addr_on && !q.tenb
                     && q.shreg[7:3] == ITC_TENB_PFX && q.shreg[2:1] == ext_addr[9:8]) begin
                     n.sda_oe = 1'b1;
                     n.tenb = 1'b1;
                     n.rw = q.shreg[0];
                  end else if (ackd && q.tenb && q.shreg == ext_addr[7:0]) begin
                     n.sda_oe = 1'b1;
                     n.slave = 1'b1;
                     n.gcall = 1'b0;
                     n.pend = q.rw ? ITC_S_SR_ACK : ITC_S_SW_ACK;
                  end else begin
                     // Not for us: wait for the next START
                     n.st = ITC_IDLE;
                  end
               end
            end else if (fall && q.tx) begin
               n.sda_oe = ~q.shreg[7];
            end
         end
         ITC_ACK: begin
            if (rise) begin
               n.ack_in = ~sda_v;
            end
            if (fall) begin
               n.sda_oe = 1'b0;
               n.cnt = 4'd0;
               if (q.tenb && !q.slave) begin
                  n.st = ITC_BYTE;
               end else begin
                  n.st = ITC_HOLD;
                  n.scl_oe = 1'b1;
                  hw_set = 1'b1;
                  hw_code = q.pend;
                  n.first = 1'b0;
                  if (q.master && q.first) begin
                     hw_code = q.shreg[0] ? (q.ack_in ? ITC_S_AR_ACK : ITC_S_AR_NAK)
                        : (q.ack_in ? ITC_S_AW_ACK : ITC_S_AW_NAK);
                     n.tx = ~q.shreg[0];
                  end else if (q.master && q.tx) begin
                     hw_code = q.ack_in ? ITC_S_TX_ACK : ITC_S_TX_NAK;
                  end else if (q.tx) begin
                     hw_code = !q.ack_in ? ITC_S_STX_NAK
                        : (q.last ? ITC_S_SLAST : ITC_S_STX_ACK);
                     n.done = ~q.ack_in | q.last;
                  end else if (!q.master) begin
                     n.tx = q.rw;
                  end
               end
            end
         end
         ITC_HOLD: begin
            n.scl_oe = 1'b1;
            if (!q.flag) begin
               if (q.stop_req && q.master) begin
                  n.st = ITC_STOP;
                  n.ph = 2'd0;
               end else if (q.stop_req || q.done) begin
                  n.stop_req = 1'b0;
                  n.slave = 1'b0;
                  n.done = 1'b0;
                  n.scl_oe = 1'b0;
                  n.st = ITC_IDLE;
               end else if (q.begin_req && q.master) begin
                  n.st = ITC_START;
                  n.ph = 2'd0;
               end else begin
                  n.st = ITC_BYTE;
                  n.cnt = 4'd0;
                  // Master keeps the clock low; its own toggling releases it
                  if (!q.master) begin
                     n.scl_oe = 1'b0;
                  end
                  if (q.tx) begin
                     n.shreg = tx_byte;
                     n.sda_oe = ~tx_byte[7];
                     n.last = ~q.ack_on;
                  end
               end
            end
         end
         ITC_STOP: begin
            // Data low under low clock, release clock, then release data
            if (m_tick) begin
               unique case (q.ph)
                  2'd0: begin
                     n.sda_oe = 1'b1;
                     n.ph = 2'd1;
                  end
                  2'd1: begin
                     n.scl_oe = 1'b0;
                     n.ph = 2'd2;
                  end
                  2'd2: begin
                     if (scl_v) begin
                        n.ph = 2'd3;
                     end
                  end
                  2'd3: begin
                     n.sda_oe = 1'b0;
                     n.master = 1'b0;
                     n.stop_req = 1'b0;
                     n.st = ITC_IDLE;
                  end
               endcase
            end
         end
      endcase

      // START or STOP from another master ends any slave or listening phase
      if (!q.master && q.st != ITC_IDLE && q.st != ITC_START && (s_start || s_stop)) begin
         if (q.slave) begin
            hw_set = 1'b1;
            hw_code = ITC_S_SSTOP;
         end
         n.slave = 1'b0;
         n.done = 1'b0;
         n.sda_oe = 1'b0;
         n.scl_oe = 1'b0;
         n.first = 1'b1;
         n.tenb = 1'b0;
         n.tx = 1'b0;
         n.cnt = 4'd0;
         n.st = s_start ? ITC_BYTE : ITC_IDLE;
      end

      // Host writes; an event in the same cycle wins over a clear
      if (cpu_req.wr && cpu_req.addr == ITC_A_CTRL) begin
         n.irq_on = cpu_req.wdata[ITC_B_IRQ];
         n.ctl_on = cpu_req.wdata[ITC_B_ON];
         n.ack_on = cpu_req.wdata[ITC_B_ACK];
         if (cpu_req.wdata[ITC_B_BEGIN]) begin
            n.begin_req = 1'b1;
         end
         if (cpu_req.wdata[ITC_B_STOP]) begin
            n.stop_req = 1'b1;
         end
         if (!cpu_req.wdata[ITC_B_FLAG]) begin
            n.flag = 1'b0;
         end
      end
      if (hw_set) begin
         n.flag = 1'b1;
         n.status = hw_code;
      end
      // Any write to the reset location aborts the bus activity
      if (cpu_req.wr && cpu_req.addr == ITC_A_SRST) begin
         n.st = ITC_IDLE;
         n.begin_req = 1'b0;
         n.stop_req = 1'b0;
         n.flag = 1'b0;
         n.master = 1'b0;
         n.slave = 1'b0;
         n.done = 1'b0;
         n.tenb = 1'b0;
         n.sda_oe = 1'b0;
         n.scl_oe = 1'b0;
      end
      if (!n.flag) begin
         n.status = ITC_S_NONE;
      end
      n.irq = n.irq_on & n.flag;

      // Host reads, answered on the next edge
      ctrl[ITC_B_IRQ] = q.irq_on;
      ctrl[ITC_B_ON] = q.ctl_on;
      ctrl[ITC_B_BEGIN] = q.begin_req;
      ctrl[ITC_B_STOP] = q.stop_req;
      ctrl[ITC_B_FLAG] = q.flag;
      ctrl[ITC_B_ACK] = q.ack_on;
      if (cpu_req.rd) begin
         if (cpu_req.addr == ITC_A_CTRL) begin
            n.rdata = ctrl;
         end else if (cpu_req.addr == ITC_A_STAT) begin
            n.rdata = q.status;
         end else begin
            n.rdata = 8'h00;
         end
      end
   end

   // State register; the bus idles high so line history starts high
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
         q.status <= ITC_STAT_RST;
         q.sda_sy <= 3'h7;
         q.scl_sy <= 3'h7;
         q.sda_f <= 1'b1;
         q.scl_f <= 1'b1;
         q.sda_p <= 1'b1;
         q.scl_p <= 1'b1;
      end else begin
         q <= n;
      end
   end
endmodule : itc_ctrl
`default_nettype wire

// [logic/itc_fifo.sv]
// Receive byte FIFO with a registered output stage.
// Assumes one clock; holds DEPTH words plus one in the output register.
`timescale 1ns/10ps
`default_nettype none
module itc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [CW-1:0] cnt;
      logic ov;
      logic [WIDTH-1:0] od;
   } itc_fifo_regs_t;
   itc_fifo_regs_t q;
   itc_fifo_regs_t n;
   logic push;
   logic pull;

   // Ready and output data come from flops only
   assign in_ready = (q.cnt != CW'(DEPTH));
   assign out_valid = q.ov;
   assign out_data = q.od;

   // Output register refills from memory whenever it empties or is taken
   always_comb begin
      n = q;
      push = in_valid & in_ready;
      pull = (q.cnt != '0) & (~q.ov | out_ready);
      if (out_ready) begin
         n.ov = 1'b0;
      end
      if (pull) begin
         n.ov = 1'b1;
         n.od = q.mem[q.rd];
         n.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
      end
      if (push) begin
         n.mem[q.wr] = in_data;
         n.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
      end
      n.cnt = q.cnt + CW'(push) - CW'(pull);
   end

   // State register
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
endmodule : itc_fifo
`default_nettype wire

// [verif/itc_bus_slave.sv]
// Bus slave: acks all, read bytes count up from A5h.
// Assumes bench-resolved lines.
`timescale 1ns/10ps
`default_nettype none
module itc_bus_slave (
   // Resolved lines and data pull-down
   input wire logic scl,
   input wire logic sda,
   output logic sda_oe
);
   int n = 0;
   logic adr = 1'b1;
   logic rd = 1'b0;
   logic [7:0] tx = 8'hA5;
   initial sda_oe = 1'b0;
   // START or STOP: new frame, line let go
   always @(sda) if (scl) begin
      n = 0;
      adr = 1'b1;
      rd = 1'b0;
      sda_oe <= 1'b0;
   end
   // Count bits; a NAK ends a read
   always @(posedge scl) begin
      n = n + 1;
      if (n == 8 && adr) rd = sda;
      if (n == 9 && !adr && sda) rd = 1'b0;
   end
   // Low clock: ack slot, else data MSB first
   always @(negedge scl) begin
      if (n == 9) begin
         if (!adr && rd) tx = tx + 8'h01;
         n = 0;
         adr = 1'b0;
      end
      sda_oe <= (n == 8) ? (adr || !rd) : (rd && !adr && !tx[7 - n]);
   end
endmodule : itc_bus_slave
`default_nettype wire

// [verif/itc_ctrl_asserts.sv]
// Port checker.
// Assumes a bind onto itc_ctrl.
`timescale 1ns/10ps
`default_nettype none
module itc_ctrl_asserts #(
   parameter int FIFO_DEPTH = 32
) (
   // Clock, reset and host port
   input wire logic clock,
   input wire logic sys_rst,
   input wire itc_pkg::itc_cpu_req_t cpu_req,
   input wire logic [7:0] cpu_rdata,
   input wire logic interrupt_line,
   // Bus pins
   input wire logic data_line_out,
   input wire logic data_line_oe,
   input wire logic clock_line_out,
   input wire logic clock_line_oe
);
   import itc_pkg::*;
   logic on_q;
   logic ien_q;
   wire logic w_ctl = cpu_req.wr && cpu_req.addr == ITC_A_CTRL;
   // Last written on/allow bits
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         on_q <= 1'b0;
         ien_q <= 1'b0;
      end else if (w_ctl) begin
         on_q <= cpu_req.wdata[ITC_B_ON];
         ien_q <= cpu_req.wdata[ITC_B_IRQ];
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   property p_irq_off;
      !ien_q && !$past(ien_q, 2) |-> !interrupt_line;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt while disallowed");
   // Line may free on the clearing edge
   property p_stretch;
      interrupt_line [*3] |-> $past(clock_line_oe);
   endproperty
   a_stretch: assert property (p_stretch) else $error("clock not held");
   property p_clear;
      w_ctl && !cpu_req.wdata[ITC_B_FLAG] && interrupt_line |-> ##2 !interrupt_line;
   endproperty
   a_clear: assert property (p_clear) else $error("interrupt kept after clear");
   property p_srst;
      cpu_req.wr && cpu_req.addr == ITC_A_SRST |-> ##2 !interrupt_line && !clock_line_oe
         && !data_line_oe;
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset left lines held");
   property p_off;
      !on_q && !$past(on_q, 3) |-> !data_line_oe && !clock_line_oe;
   endproperty
   a_off: assert property (p_off) else $error("driving while off");
   property p_idle_code;
      cpu_req.rd && cpu_req.addr == ITC_A_CTRL ##1 cpu_req.rd && cpu_req.addr == ITC_A_STAT
         && !cpu_rdata[ITC_B_FLAG] |=> cpu_rdata == ITC_S_NONE;
   endproperty
   a_idle_code: assert property (p_idle_code) else $error("status not idle code");
   property p_stat_low;
      cpu_req.rd && cpu_req.addr == ITC_A_STAT |=> cpu_rdata[2:0] == 3'h0;
   endproperty
   a_stat_low: assert property (p_stat_low) else $error("status low bits set");
   property p_od;
      data_line_out == 1'b0 && clock_line_out == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("pin driven high");
   c_flag: cover property ($rose(interrupt_line));
   c_release: cover property ($fell(clock_line_oe));
   c_srst: cover property (cpu_req.wr && cpu_req.addr == ITC_A_SRST);
endmodule : itc_ctrl_asserts
`default_nettype wire

// [verif/itc_ctrl_tb.sv]
// Bench: registers, master write/read, STOP, soft reset.
// Assumes the slave model.
`timescale 1ns/10ps
`default_nettype none
module itc_ctrl_tb;
   import itc_pkg::*;
   typedef struct {logic [2:0] wa; logic [7:0] wd; logic [2:0] ra; logic [7:0] ex;} itc_row_t;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   itc_cpu_req_t cpu_req = '0;
   logic [7:0] tx_byte = 8'h00;
   logic rx_ready = 1'b0;
   logic [7:0] cpu_rdata, rx_data, rdv;
   logic interrupt_line, rx_valid, sda_oe, scl_oe, m_oe;
   wire logic sda = !(sda_oe || m_oe);
   wire logic scl = !scl_oe;
   int mismatches = 0;
   int checked = 0;
   int stops = 0;
   itc_row_t rows [5] = '{'{ITC_A_CTRL, 8'hC4, ITC_A_CTRL, 8'hC4},
      '{ITC_A_CTRL, 8'h0C, ITC_A_CTRL, 8'h04}, '{ITC_A_STAT, 8'h55, ITC_A_STAT, ITC_S_NONE},
      '{3'h5, 8'h77, 3'h5, 8'h00}, '{ITC_A_CTRL, 8'h40, ITC_A_CTRL, 8'h40}};
   itc_ctrl u_itc_ctrl (.clock(clock), .sys_rst(sys_rst), .cpu_req(cpu_req),
      .cpu_rdata(cpu_rdata), .interrupt_line(interrupt_line), .slave_addr(7'h3A),
      .general_call_accept(1'b0), .ext_addr_on(1'b0), .ext_addr(10'h000), .tx_byte(tx_byte),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .data_line_input(sda),
      .data_line_out(), .data_line_oe(sda_oe), .clock_line_input(scl), .clock_line_out(),
      .clock_line_oe(scl_oe));
   itc_bus_slave u_itc_bus_slave (.scl(scl), .sda(sda), .sda_oe(m_oe));
   always #20 clock = !clock;
   // STOP: data rises, clock high
   always @(posedge sda) if (scl && !sys_rst) stops++;
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   // Held over one edge
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      cpu_req = '{w, !w, a, d};
      @(posedge clock);
      #1;
      rdv = cpu_rdata;
   endtask : acc
   task automatic idle();
      cpu_req = '0;
      @(posedge clock);
      #1;
   endtask : idle
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
      idle();
   endtask : wr
   task automatic chk(input logic [7:0] ec, input logic [7:0] es);
      acc(1'b0, ITC_A_CTRL, 8'h00);
      cmp("control", ec, rdv);
      acc(1'b0, ITC_A_STAT, 8'h00);
      cmp("status", es, rdv);
      idle();
   endtask : chk
   // Write, await next state
   task automatic step(input logic [7:0] d, input logic [7:0] ec, input logic [7:0] es);
      int i;
      wr(ITC_A_CTRL, d);
      repeat (2) @(posedge clock);
      for (i = 0; i < 4000 && !interrupt_line; i++) @(posedge clock);
      #1;
      chk(ec, es);
   endtask : step
   task automatic summarize();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize
   initial begin
      int r;
      int i;
      repeat (16) @(posedge clock);
      #1;
      cmp("pins", 8'h00, {5'h0, interrupt_line, sda_oe, scl_oe});
      sys_rst = 1'b0;
      chk(ITC_CTRL_RST, ITC_STAT_RST);
      for (r = 0; r < 5; r++) begin
         wr(rows[r].wa, rows[r].wd);
         acc(1'b0, rows[r].ra, 8'h00);
         idle();
         cmp("register", rows[r].ex, rdv);
      end
      tx_byte = 8'h54;
      step(8'hE4, 8'hCC, ITC_S_START);
      cmp("stretch", 8'h01, {7'h0, scl_oe});
      step(8'hC4, 8'hCC, ITC_S_AW_ACK);
      tx_byte = 8'h3C;
      step(8'hC4, 8'hCC, ITC_S_TX_ACK);
      step(8'hE4, 8'hCC, ITC_S_RSTART);
      tx_byte = 8'h55;
      step(8'hC4, 8'hCC, ITC_S_AR_ACK);
      step(8'hC4, 8'hCC, ITC_S_RX_ACK);
      step(8'hC4, 8'hCC, ITC_S_RX_ACK);
      step(8'hC0, 8'hC8, ITC_S_RX_NAK);
      wr(ITC_A_CTRL, 8'hD0);
      for (r = 0; r < 2000 && stops == 0; r++) @(posedge clock);
      repeat (ITC_HALF_CYC) @(posedge clock);
      #1;
      chk(8'hC0, ITC_S_NONE);
      cmp("stops", 8'h01, stops[7:0]);
      rx_ready = 1'b1;
      for (r = 0; r < 3; r++) begin
         for (i = 0; i < 8 && rx_valid !== 1'b1; i++) #40;
         cmp("rx", 8'hA5 + r[7:0], rx_data);
         @(posedge clock);
         #1;
      end
      cmp("empty", 8'h00, {7'h0, rx_valid});
      step(8'hE4, 8'hCC, ITC_S_START);
      wr(ITC_A_SRST, 8'h5A);
      chk(8'hC4, ITC_S_NONE);
      summarize();
   end
   // About five times the run
   initial begin
      #(40 * 80000);
      mismatches++;
      summarize();
   end
endmodule : itc_ctrl_tb
bind itc_ctrl itc_ctrl_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_itc_ctrl_asserts (
   .clock(clock), .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
   .interrupt_line(interrupt_line), .data_line_out(data_line_out),
   .data_line_oe(data_line_oe), .clock_line_out(clock_line_out),
   .clock_line_oe(clock_line_oe));
`default_nettype wire
